// ---- design/srmi_map.svh ----
// Constants for the switch reset mode init block: register offsets,
// field positions, partition and port mode values, mode codes and timing counts.
// Assumes a 25 MHz core clock and a byte-addressed register port.
`ifndef SRMI_MAP_SVH
`define SRMI_MAP_SVH

// ****************************************************************
// Register offsets (byte addresses, one word each)
// ****************************************************************
`define SRMI_SWITCH_CONTROL_REG_OFS        8'h00
`define SRMI_STATUS_OFS       8'h04
`define SRMI_PARTST_OFS       8'h08
`define SRMI_PORTMD_LO_OFS    8'h0c
`define SRMI_PORTMD_HI_OFS    8'h10
`define SRMI_EECTL_OFS        8'h14

// ****************************************************************
// Field positions
// ****************************************************************
`define SRMI_SWITCH_CONTROL_REG_HALT_BIT   0
`define SRMI_SWITCH_CONTROL_REG_UNLK_BIT   1
`define SRMI_EECTL_DONE_BIT   0
`define SRMI_EECTL_ERR_BIT    1

// ****************************************************************
// Partition state and port mode values
// ****************************************************************
`define SRMI_PART_ACTIVE      2'h1
`define SRMI_PART_DISABLED    2'h0
`define SRMI_PMODE_DOWN       3'h1
`define SRMI_PMODE_UP         3'h2
`define SRMI_PMODE_OFF        3'h0
`define SRMI_PMODE_UNATT      3'h5

// ****************************************************************
// Switch mode codes
// ****************************************************************
`define SRMI_SM_SP            4'h0
`define SRMI_SM_SP_EE         4'h1
`define SRMI_SM_MP            4'hc
`define SRMI_SM_MP_EE         4'hd
`define SRMI_SM_P0            4'h8
`define SRMI_SM_P0_EE         4'ha
`define SRMI_SM_P2            4'h9
`define SRMI_SM_P2_EE         4'hb

// ****************************************************************
// Timing
// ****************************************************************
`define SRMI_CLK_KHZ          25000
`define SRMI_CFG_MS           100
`define SRMI_CFG_CYC          (`SRMI_CFG_MS * `SRMI_CLK_KHZ)
`define SRMI_EE_MS            200
`define SRMI_EE_CYC           (`SRMI_EE_MS * `SRMI_CLK_KHZ)
`define SRMI_SUCC_MS          1000
`define SRMI_SUCC_CYC         (`SRMI_SUCC_MS * `SRMI_CLK_KHZ)

`endif

// ---- design/srmi_pkg.sv ----
// Types for the switch reset mode init block.
// Assumes srmi_map.svh is compiled alongside.
package srmi_pkg;

	// ****************************************************************
	// Mode class and sequence state
	// ****************************************************************
	typedef enum logic [2:0] {
		SRMI_CLS_SP,
		SRMI_CLS_MP,
		SRMI_CLS_P0,
		SRMI_CLS_P2,
		SRMI_CLS_TEST
	} srmi_class_e;

	typedef enum logic [2:0] {
		SRMI_ST_LINK,
		SRMI_ST_EELOAD,
		SRMI_ST_QUASI,
		SRMI_ST_UNLOCK,
		SRMI_ST_INIT,
		SRMI_ST_RUN
	} srmi_state_e;

	typedef logic [1:0]  srmi_pstate_t;
	typedef logic [2:0]  srmi_pmode_t;
	typedef logic [31:0] srmi_word_t;

endpackage : srmi_pkg

// ---- design/srmi_cfg_if.sv ----
// Carries the mode-dependent initial values from the decoder to the
// sequencer. Assumes both ends share core_clk.
`timescale 1ns/1ns
interface srmi_cfg_if;
	import srmi_pkg::*;
	logic [3:0]          switch_mode_strap; // Sampled mode code
	srmi_class_e         mode_class;        // Decoded class
	logic                ee_load;           // Mode loads EEPROM
	srmi_pstate_t [15:0] part_init;         // Partition states
	srmi_pmode_t  [15:0] port_init;         // Port operating modes
	modport dec (input switch_mode_strap, output mode_class, ee_load,
		part_init, port_init);
	modport seq (output switch_mode_strap, input mode_class, ee_load,
		part_init, port_init);
endinterface : srmi_cfg_if

// ---- design/srmi_mode_dec.sv ----
// Decodes the sampled switch mode into initial partition and port
// values. Purely combinational; assumes the code is stable.
`timescale 1ns/1ns
`include "srmi_map.svh"
module srmi_mode_dec (
	srmi_cfg_if.dec cfg
);
	import srmi_pkg::*;

	// ****************************************************************
	// Mode decode
	// ****************************************************************
	// EEPROM variants map onto the same class as their plain twin
	always_comb begin
		cfg.ee_load = 1'b0;
		unique case (cfg.switch_mode_strap) // see [R9] see [R11]
			`SRMI_SM_SP: cfg.mode_class = SRMI_CLS_SP;
			`SRMI_SM_SP_EE: begin
				cfg.mode_class = SRMI_CLS_SP; // see [R10]
				cfg.ee_load = 1'b1;
			end
			`SRMI_SM_MP: cfg.mode_class = SRMI_CLS_MP;
			`SRMI_SM_MP_EE: begin
				cfg.mode_class = SRMI_CLS_MP;
				cfg.ee_load = 1'b1;
			end
			`SRMI_SM_P0: cfg.mode_class = SRMI_CLS_P0;
			`SRMI_SM_P0_EE: begin
				cfg.mode_class = SRMI_CLS_P0;
				cfg.ee_load = 1'b1;
			end
			`SRMI_SM_P2: cfg.mode_class = SRMI_CLS_P2;
			`SRMI_SM_P2_EE: begin
				cfg.mode_class = SRMI_CLS_P2;
				cfg.ee_load = 1'b1;
			end
			default: cfg.mode_class = SRMI_CLS_TEST;
		endcase
	end

	// ****************************************************************
	// Initial values
	// ****************************************************************
	// Test modes get the single-partition values as a safe fallback
	always_comb begin
		for (int i = 0; i < 16; i++) begin
			cfg.part_init[i] = `SRMI_PART_DISABLED; // see [R12]
			cfg.port_init[i] = `SRMI_PMODE_DOWN; // see [R13] see [R14]
		end
		unique case (cfg.mode_class)
			SRMI_CLS_MP: begin
				for (int i = 0; i < 16; i++)
					cfg.port_init[i] = `SRMI_PMODE_UNATT;
			end
			SRMI_CLS_P0: begin
				cfg.part_init[0] = `SRMI_PART_ACTIVE;
				cfg.port_init[0] = `SRMI_PMODE_UP;
				cfg.port_init[2] = `SRMI_PMODE_OFF;
			end
			SRMI_CLS_P2: begin
				cfg.part_init[0] = `SRMI_PART_ACTIVE;
				cfg.port_init[2] = `SRMI_PMODE_UP;
				cfg.port_init[0] = `SRMI_PMODE_OFF;
			end
			default: begin
				cfg.part_init[0] = `SRMI_PART_ACTIVE;
				cfg.port_init[0] = `SRMI_PMODE_UP;
			end
		endcase
	end

endmodule : srmi_mode_dec

// ---- design/srmi_seq.sv ----
// Closing steps of the switch fundamental reset: EEPROM load wait,
// quasi-reset hold, unlock clear and mode-dependent initialisation.
// Assumes a single 25 MHz core clock and synchronous inputs.
//
// How it works
// [R1] Halt flag set keeps ports in quasi-reset
// [R2] Agent clears halt flag after its setup
// [R3] Unlock bit cleared after quasi-reset stage
// [R4] Run in the sampled switch mode
// [R5] Config requests answered within 100 ms
// [R6] Successful answers within 1 s, EEPROM 200 ms
// [R7] 200 ms EEPROM budget ample at 100 kHz
// [R8] EEPROM write side effects start at write
// [R9] Eight normal modes, rest are test
// [R10] EEPROM variant equals plain mode otherwise
// [R11] Mode code decode table
// [R12] Partition initial states per mode
// [R13] Port operating modes per mode
// [R14] Single partition: port 0 up, rest down
// [R15] Single partition: only partition 0 configurable
// [R16] Quasi-reset: retry type 0, drop others
// [R17] EEPROM error aborts load, sets halt
// [R18] Halt clear releases all ports next clock; here RUN follows two clocks after the halt flag clears, via UNLOCK and INIT
`timescale 1ns/1ns
`include "srmi_map.svh"
module srmi_seq (
	input  wire logic             core_clk,
	input  wire logic             reset_n,
	input  wire logic [3:0]       switch_mode_strap,
	input  wire logic             halt_strap,
	input  wire logic             link_ready,
	input  wire logic             ee_word_valid,
	input  wire logic [7:0]       ee_word_addr,
	input  wire logic [31:0]      ee_word_data,
	input  wire logic             ee_error,
	input  wire logic             ee_last,
	input  wire logic             cfg_req_valid,
	input  wire logic             cfg_req_type0,
	input  wire logic [7:0]       reg_addr,
	input  wire logic [31:0]      reg_wdata,
	input  wire logic             reg_wr,
	input  wire logic             reg_rd,
	output logic      [31:0]      reg_rdata,
	output logic                  quasi_reset,
	output logic                  cpl_retry,
	output logic                  cpl_normal,
	output logic                  pkt_discard,
	output logic                  credit_return,
	output logic                  retrain_pulse,
	output logic                  normal_op,
	output logic                  test_mode,
	output srmi_pkg::srmi_pstate_t [15:0] partition_state_field,
	output srmi_pkg::srmi_pmode_t  [15:0] port_operating_mode_field,
	output logic                  cfg_late
);
	import srmi_pkg::*;

	// ****************************************************************
	// Decoder link
	// ****************************************************************
	srmi_cfg_if cfg_bus ();

	srmi_mode_dec u_dec (
		.cfg (cfg_bus)
	);

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		srmi_state_e            st;         // Sequence position
		logic [3:0]             mode;       // Captured mode code
		logic                   captured;   // Strap caught once
		logic                   halt;       // Reset-halt flag
		logic                   unlock;     // Register-unlock bit
		logic                   ee_done;    // EEPROM load done
		logic                   ee_err;     // EEPROM load error
		logic [31:0]            cyc;        // Cycles since release
		logic                   late;       // Deadline missed
		srmi_pstate_t [15:0]    part;       // Partition states
		srmi_pmode_t  [15:0]    port;       // Port modes
		logic [31:0]            rdata;      // Read data
		logic                   retry;      // Retry completion
		logic                   cpl;        // Normal completion
		logic                   discard;    // Packet dropped
		logic                   credit;     // Credits returned
		logic                   retrain;    // Retrain side effect
	} srmi_state_s;

	srmi_state_s s_r;   // Registered state
	srmi_state_s s_nxt; // Next state
	logic [3:0]  mode_r;
	assign mode_r = s_r.mode;
	// Decoder sees only the captured code, never the live strap
	assign cfg_bus.switch_mode_strap = mode_r;

	// Register address helper: shared by bus writes, EEPROM writes and the read mux
	function automatic logic is_addr(input logic [7:0] a,
		input logic [7:0] ofs);
		is_addr = (a == ofs);
	endfunction : is_addr

	// ****************************************************************
	// Next-state logic
	// ****************************************************************
	always_comb begin
		logic         wr_any;
		logic [7:0]   wa;
		logic [31:0]  wd;
		logic         single;
		wr_any = 1'b0;
		wa = 8'h00;
		wd = 32'h0000_0000;
		single = 1'b0;
		s_nxt = s_r;
		s_nxt.retry = 1'b0;
		s_nxt.cpl = 1'b0;
		s_nxt.discard = 1'b0;
		s_nxt.credit = 1'b0;
		s_nxt.retrain = 1'b0;
		s_nxt.rdata = 32'h0000_0000;
		single = (cfg_bus.mode_class != SRMI_CLS_MP);

		// Catch the strap on the first clock after release
		if (!s_r.captured) begin
			s_nxt.captured = 1'b1;
			s_nxt.mode = switch_mode_strap;
			s_nxt.halt = halt_strap;
		end

		// Deadline counter; saturates to avoid wrap
		if (s_r.cyc != 32'hffff_ffff)
			s_nxt.cyc = s_r.cyc + 32'h0000_0001;
		if (s_r.st != SRMI_ST_RUN &&
			s_r.cyc >= 32'(`SRMI_SUCC_CYC)) // see [R6]
			s_nxt.late = 1'b1;
		if (s_r.st == SRMI_ST_EELOAD &&
			s_r.cyc >= 32'(`SRMI_EE_CYC)) // see [R7]
			s_nxt.late = 1'b1;

		// Pick one write source: EEPROM has priority during load
		if (s_r.st == SRMI_ST_EELOAD && ee_word_valid) begin
			wr_any = 1'b1;
			wa = ee_word_addr;
			wd = ee_word_data;
		end else if (reg_wr) begin
			wr_any = 1'b1;
			wa = reg_addr;
			wd = reg_wdata;
		end

		// Register writes take effect in the cycle they occur
		if (wr_any) begin
			if (is_addr(wa, `SRMI_SWITCH_CONTROL_REG_OFS)) begin
				s_nxt.halt = wd[`SRMI_SWITCH_CONTROL_REG_HALT_BIT]; // see [R2]
				s_nxt.unlock = wd[`SRMI_SWITCH_CONTROL_REG_UNLK_BIT];
				s_nxt.retrain = 1'b0;
			end
			if (is_addr(wa, `SRMI_EECTL_OFS) &&
				wd[`SRMI_EECTL_DONE_BIT])
				s_nxt.retrain = 1'b1; // see [R8]
			if (is_addr(wa, `SRMI_PARTST_OFS)) begin
				for (int i = 0; i < 16; i++)
					if (!single || i == 0) // see [R15]
						s_nxt.part[i] = wd[2*i +: 2];
			end
			if (is_addr(wa, `SRMI_PORTMD_LO_OFS)) begin
				for (int i = 0; i < 8; i++)
					s_nxt.port[i] = wd[4*i +: 3];
			end
			if (is_addr(wa, `SRMI_PORTMD_HI_OFS)) begin
				for (int i = 0; i < 8; i++)
					s_nxt.port[i+8] = wd[4*i +: 3];
			end
		end

		// Sequence
		unique case (s_r.st)
			SRMI_ST_LINK: begin
				if (s_r.captured && link_ready)
					s_nxt.st = cfg_bus.ee_load ?
						SRMI_ST_EELOAD : SRMI_ST_QUASI;
			end
			SRMI_ST_EELOAD: begin
				if (ee_error) begin
					s_nxt.ee_err = 1'b1;
					s_nxt.halt = 1'b1; // see [R17]
					s_nxt.st = SRMI_ST_QUASI;
				end else if (ee_last) begin
					s_nxt.ee_done = 1'b1;
					s_nxt.st = SRMI_ST_QUASI;
				end
			end
			SRMI_ST_QUASI: begin
				if (!s_nxt.halt) // see [R1] see [R18]
					s_nxt.st = SRMI_ST_UNLOCK;
			end
			SRMI_ST_UNLOCK: begin
				s_nxt.unlock = 1'b0; // see [R3]
				s_nxt.st = SRMI_ST_INIT;
			end
			SRMI_ST_INIT: begin
				s_nxt.part = cfg_bus.part_init; // see [R12]
				s_nxt.port = cfg_bus.port_init; // see [R13] see [R14]
				s_nxt.st = SRMI_ST_RUN; // see [R4]
			end
			SRMI_ST_RUN: begin
				if (s_nxt.halt)
					s_nxt.st = SRMI_ST_QUASI;
			end
		endcase

		// Config request handling: retry type 0 and drop others unless running
		if (cfg_req_valid) begin
			if (s_r.st == SRMI_ST_RUN) begin
				s_nxt.cpl = 1'b1; // see [R5]
			end else if (cfg_req_type0) begin
				s_nxt.retry = 1'b1; // see [R16]
			end else begin
				s_nxt.discard = 1'b1;
				s_nxt.credit = 1'b1;
			end
		end

		// Read mux; unmapped addresses read zero
		if (reg_rd) begin
			if (is_addr(reg_addr, `SRMI_SWITCH_CONTROL_REG_OFS)) begin
				s_nxt.rdata[`SRMI_SWITCH_CONTROL_REG_HALT_BIT] = s_r.halt;
				s_nxt.rdata[`SRMI_SWITCH_CONTROL_REG_UNLK_BIT] = s_r.unlock;
			end else if (is_addr(reg_addr, `SRMI_STATUS_OFS)) begin
				s_nxt.rdata[3:0] = s_r.mode;
				s_nxt.rdata[6:4] = 3'(s_r.st);
				s_nxt.rdata[7] = s_r.late;
			end else if (is_addr(reg_addr, `SRMI_PARTST_OFS)) begin
				s_nxt.rdata = s_r.part;
			end else if (is_addr(reg_addr, `SRMI_PORTMD_LO_OFS)) begin
				for (int i = 0; i < 8; i++)
					s_nxt.rdata[4*i +: 3] = s_r.port[i];
			end else if (is_addr(reg_addr, `SRMI_PORTMD_HI_OFS)) begin
				for (int i = 0; i < 8; i++)
					s_nxt.rdata[4*i +: 3] = s_r.port[i+8];
			end else if (is_addr(reg_addr, `SRMI_EECTL_OFS)) begin
				s_nxt.rdata[`SRMI_EECTL_DONE_BIT] = s_r.ee_done;
				s_nxt.rdata[`SRMI_EECTL_ERR_BIT] = s_r.ee_err;
			end
		end
	end

	// ****************************************************************
	// State register
	// ****************************************************************
	// Reset leaves ports parked and the unlock bit open for loading
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			s_r <= '0;
			s_r.st <= SRMI_ST_LINK;
			s_r.unlock <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ****************************************************************
	// Outputs, all straight from the state register
	// ****************************************************************
	assign reg_rdata = s_r.rdata;
	assign quasi_reset = (s_r.st != SRMI_ST_RUN); // see [R1]
	assign normal_op = (s_r.st == SRMI_ST_RUN);
	assign cpl_retry = s_r.retry;
	assign cpl_normal = s_r.cpl;
	assign pkt_discard = s_r.discard;
	assign credit_return = s_r.credit;
	assign retrain_pulse = s_r.retrain;
	assign test_mode = s_r.captured &&
		(cfg_bus.mode_class == SRMI_CLS_TEST); // see [R9]
	assign partition_state_field = s_r.part;
	assign port_operating_mode_field = s_r.port;
	assign cfg_late = s_r.late;

endmodule : srmi_seq

// ---- tb/srmi_ee_model.sv ----
// Serial EEPROM loader model: one trigger word, then done or error.
// Assumes the bench pulses start once the link is up.
`timescale 1ns/1ns
module srmi_ee_model (
	input  wire logic        core_clk,
	input  wire logic        start,
	input  wire logic        fail,
	input  wire logic        slow,
	output logic             ee_word_valid,
	output logic [7:0]       ee_word_addr,
	output logic [31:0]      ee_word_data,
	output logic             ee_error,
	output logic             ee_last
);
	// Released lines show the inverse of the last word, not a copy
	initial begin
		ee_word_valid = 1'b0;
		ee_word_addr = 8'h5a;
		ee_word_data = 32'ha5a5a5a5;
		ee_error = 1'b0;
		ee_last = 1'b0;
	end

	// ************************************************
	// Load sequence, prompt or slow
	// ************************************************
	always @(posedge core_clk) begin
		if (start) begin
			// Load ends far inside its budget either way
			repeat (slow ? 7 : 1) @(posedge core_clk);
			// Trigger word is the only word, done or error follows after a gap
			ee_word_addr <= 8'h14;
			ee_word_data <= 32'h1;
			ee_word_valid <= 1'b1;
			@(posedge core_clk);
			ee_word_valid <= 1'b0;
			ee_word_addr <= 8'heb;
			ee_word_data <= 32'hfffffffe;
			repeat (slow ? 7 : 1) @(posedge core_clk);
			// Broken load on command only
			if (fail) begin
				ee_error <= 1'b1;
			end else begin
				ee_last <= 1'b1;
			end
			@(posedge core_clk);
			ee_error <= 1'b0;
			ee_last <= 1'b0;
		end
	end
endmodule : srmi_ee_model

// ---- tb/srmi_seq_monitor.sv ----
// Port-level checker for the mode init sequencer.
// Assumes one clock domain and the async active-low reset.
`timescale 1ns/1ns
module srmi_seq_monitor (
	input wire logic                          core_clk,
	input wire logic                          reset_n,
	input wire logic                          cfg_req_valid,
	input wire logic                          cfg_req_type0,
	input wire logic                          reg_rd,
	input wire logic                          ee_word_valid,
	input wire logic [7:0]                    ee_word_addr,
	input wire logic [31:0]                   ee_word_data,
	input wire logic [31:0]                   reg_rdata,
	input wire logic                          quasi_reset,
	input wire logic                          normal_op,
	input wire logic                          cpl_retry,
	input wire logic                          cpl_normal,
	input wire logic                          pkt_discard,
	input wire logic                          credit_return,
	input wire logic                          retrain_pulse,
	input wire srmi_pkg::srmi_pstate_t [15:0] partition_state_field,
	input wire srmi_pkg::srmi_pmode_t  [15:0] port_operating_mode_field
);
	import srmi_pkg::*;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	a_op_excl: assert property (normal_op != quasi_reset)
		else $error("run and quasi-reset not exclusive");
	a_retry_type0: assert property (
		cfg_req_valid && cfg_req_type0 && quasi_reset
		|=> cpl_retry && !cpl_normal) else $error("no retry");
	a_drop_other: assert property (
		cfg_req_valid && !cfg_req_type0 && quasi_reset
		|=> pkt_discard && credit_return) else $error("no discard");
	a_run_answer: assert property (
		cfg_req_valid && !quasi_reset |=> cpl_normal && !cpl_retry)
		else $error("no normal completion");
	a_rdata_idle: assert property (
		!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data outside read slot");
	a_part_off: assert property (
		$rose(normal_op) |-> partition_state_field[15:1] == '0)
		else $error("partition above zero not disabled");
	a_part_port: assert property (
		$rose(normal_op) |-> (partition_state_field[0] == 2'h1)
		== (port_operating_mode_field[1] == 3'h1))
		else $error("partition and port modes disagree");
	a_sp_down: assert property (
		$rose(normal_op) && partition_state_field[0] == 2'h1
		|-> port_operating_mode_field[15:3] == {13{3'h1}})
		else $error("single partition ports not downstream");
	a_ee_retrain: assert property (
		ee_word_valid && ee_word_addr == 8'h14 && ee_word_data[0]
		|=> retrain_pulse) else $error("no retrain at write");
endmodule : srmi_seq_monitor

bind srmi_seq srmi_seq_monitor mon_u (.core_clk, .reset_n,
	.cfg_req_valid, .cfg_req_type0, .reg_rd, .ee_word_valid,
	.ee_word_addr, .ee_word_data, .reg_rdata, .quasi_reset,
	.normal_op, .cpl_retry, .cpl_normal, .pkt_discard,
	.credit_return, .retrain_pulse, .partition_state_field,
	.port_operating_mode_field);

// ---- tb/test_switch_reset_mode_init.sv ----
// Bench for the mode init sequencer: mode table, quasi-reset
// traffic, halt release, EEPROM load and error paths.
// Assumes the EEPROM model and the bound checker are compiled.
`timescale 1ns/1ns
module test_switch_reset_mode_init;
	import srmi_pkg::*;
	logic core_clk = 0, reset_n = 0, halt_strap = 1, link_ready = 0;
	logic [3:0] switch_mode_strap = 4'h0;
	logic cfg_req_valid = 0, cfg_req_type0 = 0, reg_wr = 0, reg_rd = 0;
	logic [7:0] reg_addr = 8'h0;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, ee_word_data;
	logic ee_start = 0, ee_fail = 0, ee_slow = 0, ee_word_valid;
	logic [7:0] ee_word_addr;
	logic ee_error, ee_last, quasi_reset, cpl_retry, cpl_normal;
	logic pkt_discard, credit_return, retrain_pulse, normal_op;
	logic test_mode, cfg_late;
	srmi_pstate_t [15:0] partition_state_field;
	srmi_pmode_t [15:0] port_operating_mode_field;
	int fails = 0, total_checks = 0, retr = 0, n;
	logic [31:0] d;
	logic [3:0] r, m;
	logic [1:0] p0;
	logic [2:0] q0, q1, q2;
	logic tm;
	logic [47:0] ep;
	logic [31:0] ew;
	// Rows: mode, partition 0, ports 0/1/2 and test flag
	logic [15:0] rows [9] = '{{4'h0, 2'h1, 3'h2, 3'h1, 3'h1, 1'h0},
		{4'h1, 2'h1, 3'h2, 3'h1, 3'h1, 1'h0},
		{4'hc, 2'h0, 3'h5, 3'h5, 3'h5, 1'h0},
		{4'hd, 2'h0, 3'h5, 3'h5, 3'h5, 1'h0},
		{4'h8, 2'h1, 3'h2, 3'h1, 3'h0, 1'h0},
		{4'ha, 2'h1, 3'h2, 3'h1, 3'h0, 1'h0},
		{4'h9, 2'h1, 3'h0, 3'h1, 3'h2, 1'h0},
		{4'hb, 2'h1, 3'h0, 3'h1, 3'h2, 1'h0},
		{4'h2, 2'h1, 3'h2, 3'h1, 3'h1, 1'h1}};

	always #20 core_clk = ~core_clk;
	always @(posedge core_clk) if (retrain_pulse === 1'b1) retr++;

	srmi_seq dut_u (.core_clk, .reset_n, .switch_mode_strap,
		.halt_strap, .link_ready, .ee_word_valid, .ee_word_addr,
		.ee_word_data, .ee_error, .ee_last, .cfg_req_valid,
		.cfg_req_type0, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .quasi_reset, .cpl_retry, .cpl_normal,
		.pkt_discard, .credit_return, .retrain_pulse, .normal_op,
		.test_mode, .partition_state_field,
		.port_operating_mode_field, .cfg_late);
	srmi_ee_model ee_u (.core_clk, .start(ee_start), .fail(ee_fail),
		.slow(ee_slow), .ee_word_valid, .ee_word_addr,
		.ee_word_data, .ee_error, .ee_last);

	task automatic stop_test();
		$display("checks %0d errors %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : stop_test

	task automatic chk(input logic [47:0] g, input logic [47:0] e);
		total_checks++;
		if (g !== e) begin
			fails++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask : rd

	task automatic req(input logic t0, output logic [3:0] v);
		@(posedge core_clk);
		cfg_req_valid <= 1'b1;
		cfg_req_type0 <= t0;
		@(posedge core_clk);
		cfg_req_valid <= 1'b0;
		#1 v = {cpl_retry, cpl_normal, pkt_discard, credit_return};
	endtask : req

	// Bounded wait after the edge so model updates have landed
	task automatic wait_for(input int which);
		n = 0;
		while (n < 60 && (which ? !normal_op : !(ee_last | ee_error)))
		begin
			@(posedge core_clk);
			#1 n++;
		end
	endtask : wait_for

	task automatic boot(input logic [3:0] md, input logic h);
		reset_n <= 1'b0;
		link_ready <= 1'b0;
		switch_mode_strap <= md;
		halt_strap <= h;
		repeat (20) @(posedge core_clk);
		reset_n <= 1'b1;
		retr = 0;
		repeat (3) @(posedge core_clk);
		link_ready <= 1'b1;
		if (md inside {4'h1, 4'hd, 4'ha, 4'hb}) begin
			repeat (3) @(posedge core_clk);
			ee_start <= 1'b1;
			@(posedge core_clk);
			ee_start <= 1'b0;
			wait_for(0);
		end
	endtask : boot

	initial begin
		repeat (20000) @(posedge core_clk);
		fails++;
		stop_test();
	end

	initial begin
		for (int i = 0; i < 9; i++) begin
			{m, p0, q0, q1, q2, tm} = rows[i];
			ee_slow <= i[0];
			boot(m, 1'b1);
			repeat (4) @(posedge core_clk);
			chk(quasi_reset, 1);
			req(1'b1, r);
			chk(r, 4'b1000);
			req(1'b0, r);
			chk(r, 4'b0011);
			rd(8'h00, d);
			chk(d, 32'h3);
			wr(8'h00, 32'h0);
			wait_for(1);
			chk(normal_op, 1);
			rd(8'h00, d);
			chk(d, 32'h0);
			rd(8'h04, d);
			chk(d[3:0], m);
			chk(test_mode, tm);
			chk(retr, m inside {4'h1, 4'hd, 4'ha, 4'hb});
			chk(partition_state_field, {30'h0, p0});
			for (int k = 0; k < 16; k++) begin
				ep[k*3+:3] = k == 0 ? q0 : k == 2 ? q2 : q1;
			end
			ew = '0;
			for (int k = 0; k < 8; k++) ew[k*4+:3] = ep[k*3+:3];
			chk(port_operating_mode_field, ep);
			rd(8'h0c, d);
			chk(d, ew);
			req(1'b1, r);
			chk(r, 4'b0100);
		end
		// Broken EEPROM load holds the ports back
		ee_fail <= 1'b1;
		boot(4'h1, 1'b0);
		ee_fail <= 1'b0;
		repeat (5) @(posedge core_clk);
		chk(quasi_reset, 1);
		rd(8'h00, d);
		chk(d[0], 1);
		rd(8'h14, d);
		chk(d[1:0], 2'b10);
		wr(8'h00, 32'h0);
		wait_for(1);
		chk(normal_op, 1);
		// No halt: runs alone, only partition 0 may change
		boot(4'h0, 1'b0);
		wait_for(1);
		chk(normal_op, 1);
		wr(8'h08, 32'hffffffff);
		rd(8'h08, d);
		chk(d[31:2], 30'h0);
		rd(8'h3c, d);
		chk(d, 32'h0);
		wr(8'h00, 32'h1);
		repeat (3) @(posedge core_clk);
		chk(quasi_reset, 1);
		chk(cfg_late, 0);
		stop_test();
	end
endmodule : test_switch_reset_mode_init
